// File: two_wire_bus_framing.sv
// Two-wire bus framing engine: master and slave bit, packet and condition logic.
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
module two_wire_bus_framing #(
  parameter int HALF_CYC = two_wire_pkg::SCL_HALF_CYC
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Power and slave setup.
  input wire logic i_serial_bus_power_reduce,
  input wire logic [6:0] i_own_addr,
  input wire logic i_gcall_enable,
  input wire logic i_s_accept,
  // Master requests.
  input wire logic i_m_valid,
  input wire logic [6:0] i_m_addr,
  input wire logic i_m_read,
  input wire logic [7:0] i_m_count,
  input wire logic i_m_keep_bus,
  output logic o_m_taken,
  output logic o_m_done,
  output logic o_m_nack,
  // Transmit byte source.
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_taken,
  // Receive buffer output.
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  // Bus status.
  output logic o_bus_busy,
  output logic o_start_seen,
  output logic o_stop_seen,
  output logic o_s_addressed,
  output logic o_s_gcall,
  // Open-drain pins.
  input wire logic i_scl_in,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe
);

  // ----------------------------------------------------------------
  // Parameter check and derived counts.
  // ----------------------------------------------------------------
  if (HALF_CYC < 4 || HALF_CYC > 65535) begin : g_bad_half
    $error("HALF_CYC must lie between 4 and 65535");
  end

  localparam logic [two_wire_pkg::CNT_W-1:0] HALF_LAST =
    two_wire_pkg::CNT_W'(HALF_CYC - 1);
  localparam logic [two_wire_pkg::CNT_W-1:0] DATA_AT =
    two_wire_pkg::CNT_W'(HALF_CYC / 2);

  // ----------------------------------------------------------------
  // Line synchronisers.
  // ----------------------------------------------------------------
  two_wire_line_if scl_line ();
  two_wire_line_if sda_line ();

  two_wire_line_sync u_scl_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_scl_in),
    .o_line(scl_line)
  );

  two_wire_line_sync u_sda_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_sda_in),
    .o_line(sda_line)
  );

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  two_wire_pkg::m_state_t m_state_reg;
  logic [two_wire_pkg::CNT_W-1:0] m_cnt_reg;
  logic [3:0] m_bit_reg;
  logic [7:0] m_shift_reg;
  logic m_sample_reg;
  logic m_addr_phase_reg;
  logic m_read_reg;
  logic [7:0] m_left_reg;
  logic m_keep_reg;
  logic m_sda_reg;
  two_wire_pkg::s_state_t s_state_reg;
  logic [3:0] s_bit_reg;
  logic [7:0] s_shift_reg;
  logic s_ack_reg;
  logic s_mack_reg;
  logic s_gc_reg;
  logic s_sda_reg;
  logic s_hold_reg;
  logic bus_busy_reg;
  logic [7:0] buf1_reg;
  logic buf1_valid_reg;
  logic start_det;
  logic stop_det;
  logic fifo_space;
  logic m_load;
  logic m_push;
  logic m_stall;
  logic m_scl_drive;
  logic s_load;
  logic s_push;
  logic push;
  logic pop;
  logic [7:0] push_data;
  logic [6:0] s_addr;
  logic s_match;

  // ----------------------------------------------------------------
  // Conditions and shared strobes.
  // ----------------------------------------------------------------
  // An SDA edge while SCL is high is a condition, never data.
  assign start_det = sda_line.fall & scl_line.level;
  assign stop_det = sda_line.rise & scl_line.level;
  assign fifo_space = ~buf1_valid_reg;
  assign pop = o_rx_valid & i_rx_ready;
  assign m_load = (m_state_reg == two_wire_pkg::M_LOW) && (m_cnt_reg == '0) &&
    (m_bit_reg == '0) && !m_addr_phase_reg && !m_read_reg && i_tx_valid;
  assign m_push = (m_state_reg == two_wire_pkg::M_LOW) && (m_cnt_reg == '0) &&
    (m_bit_reg == two_wire_pkg::BIT_ACK_SLOT) && !m_addr_phase_reg && m_read_reg &&
    fifo_space;
  // The master stretches its own low phase while it waits for a byte or room.
  assign m_stall = !m_addr_phase_reg && (m_read_reg ?
    ((m_bit_reg == two_wire_pkg::BIT_ACK_SLOT) && !fifo_space) :
    ((m_bit_reg == '0) && !i_tx_valid));
  assign m_scl_drive = (m_state_reg == two_wire_pkg::M_LOW) ||
    (m_state_reg == two_wire_pkg::M_STOP_A) || (m_state_reg == two_wire_pkg::M_HELD);
  assign s_load = s_hold_reg && !start_det && !stop_det && !m_load &&
    (s_state_reg == two_wire_pkg::S_TX) && i_tx_valid;
  assign s_push = s_hold_reg && !start_det && !stop_det && !m_push &&
    (s_state_reg == two_wire_pkg::S_RX) && fifo_space;
  assign push = m_push | s_push;
  assign push_data = m_push ? m_shift_reg : s_shift_reg;
  assign s_addr = s_shift_reg[7:1];
  // Reserved 1111xxx addresses are never answered, general call only as a write.
  assign s_match = ((s_addr == i_own_addr) && (s_addr[6:3] != two_wire_pkg::RESERVED_HI)) ||
    ((s_addr == two_wire_pkg::GCALL_ADDR) && i_gcall_enable &&
    (s_shift_reg[0] != two_wire_pkg::DIR_READ));

  // ----------------------------------------------------------------
  // Bus occupancy.
  // ----------------------------------------------------------------
  // Busy from any START (repeated ones included) until STOP.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus_busy_reg <= 1'b0;
    end else if (i_serial_bus_power_reduce) begin
      bus_busy_reg <= 1'b0;
    end else if (start_det) begin
      bus_busy_reg <= 1'b1;
    end else if (stop_det) begin
      bus_busy_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Master engine.
  // ----------------------------------------------------------------
  // Outside START and STOP, SDA only moves mid-way through a low phase, so data is steady while SCL is high.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b || i_serial_bus_power_reduce) begin
      m_state_reg <= two_wire_pkg::M_IDLE;
      m_cnt_reg <= '0;
      m_bit_reg <= '0;
      m_shift_reg <= 8'h00;
      m_sample_reg <= 1'b1;
      m_addr_phase_reg <= 1'b0;
      m_read_reg <= 1'b0;
      m_left_reg <= 8'h00;
      m_keep_reg <= 1'b0;
      m_sda_reg <= 1'b0;
      o_m_taken <= 1'b0;
      o_m_done <= 1'b0;
      o_m_nack <= 1'b0;
    end else begin
      o_m_taken <= 1'b0;
      o_m_done <= 1'b0;
      o_m_nack <= 1'b0;
      unique case (m_state_reg)
        two_wire_pkg::M_IDLE, two_wire_pkg::M_HELD: begin
          if (m_state_reg == two_wire_pkg::M_HELD && m_cnt_reg != DATA_AT) begin
            m_cnt_reg <= m_cnt_reg + 1'b1;
          end else if (m_state_reg == two_wire_pkg::M_HELD) begin
            m_sda_reg <= 1'b0;
          end
          // A fresh START needs a free, idle bus; a held bus restarts once SDA is released at DATA_AT.
          if (i_m_valid && ((m_state_reg == two_wire_pkg::M_IDLE && !bus_busy_reg &&
              scl_line.level && sda_line.level) ||
              (m_state_reg == two_wire_pkg::M_HELD && m_cnt_reg == DATA_AT))) begin
            o_m_taken <= 1'b1;
            m_shift_reg <= {i_m_addr, i_m_read};
            m_read_reg <= i_m_read;
            m_left_reg <= (i_m_count == 8'h00) ? two_wire_pkg::ONE_BYTE : i_m_count;
            m_keep_reg <= i_m_keep_bus;
            m_addr_phase_reg <= 1'b1;
            m_bit_reg <= '0;
            m_cnt_reg <= '0;
            if (m_state_reg == two_wire_pkg::M_HELD) begin
              m_state_reg <= two_wire_pkg::M_START_A;
            end else begin
              m_sda_reg <= 1'b1;
              m_state_reg <= two_wire_pkg::M_START_B;
            end
          end
        end
        two_wire_pkg::M_START_A, two_wire_pkg::M_STOP_B: begin
          // SCL released; time the high phase only once it is really high.
          if (scl_line.level) begin
            if (m_cnt_reg == HALF_LAST) begin
              m_cnt_reg <= '0;
              m_sda_reg <= (m_state_reg == two_wire_pkg::M_START_A);
              m_state_reg <= (m_state_reg == two_wire_pkg::M_START_A) ?
                two_wire_pkg::M_START_B : two_wire_pkg::M_STOP_C;
            end else begin
              m_cnt_reg <= m_cnt_reg + 1'b1;
            end
          end
        end
        two_wire_pkg::M_START_B, two_wire_pkg::M_STOP_C: begin
          if (m_cnt_reg == HALF_LAST) begin
            m_cnt_reg <= '0;
            if (m_state_reg == two_wire_pkg::M_START_B) begin
              m_state_reg <= two_wire_pkg::M_LOW;
            end else begin
              o_m_done <= 1'b1;
              m_state_reg <= two_wire_pkg::M_IDLE;
            end
          end else begin
            m_cnt_reg <= m_cnt_reg + 1'b1;
          end
        end
        two_wire_pkg::M_LOW: begin
          if (m_load) begin
            m_shift_reg <= i_tx_data;
          end
          if (m_cnt_reg == DATA_AT) begin
            if (m_bit_reg != two_wire_pkg::BIT_ACK_SLOT) begin
              m_sda_reg <= (m_addr_phase_reg || !m_read_reg) && !m_shift_reg[7];
            end else begin
              // Receiving: acknowledge all but the last byte; sending: release.
              m_sda_reg <= !m_addr_phase_reg && m_read_reg &&
                (m_left_reg != two_wire_pkg::ONE_BYTE);
            end
          end
          if (m_cnt_reg == '0 && m_stall) begin
            m_cnt_reg <= '0;
          end else if (m_cnt_reg == HALF_LAST) begin
            m_cnt_reg <= '0;
            m_state_reg <= two_wire_pkg::M_HIGH;
          end else begin
            m_cnt_reg <= m_cnt_reg + 1'b1;
          end
        end
        two_wire_pkg::M_HIGH: begin
          if (scl_line.level) begin
            if (m_cnt_reg == '0) begin
              m_sample_reg <= sda_line.level;
            end
            if (m_cnt_reg != HALF_LAST) begin
              m_cnt_reg <= m_cnt_reg + 1'b1;
            end else begin
              m_cnt_reg <= '0;
              m_state_reg <= two_wire_pkg::M_LOW;
              if (m_bit_reg != two_wire_pkg::BIT_ACK_SLOT) begin
                m_shift_reg <= {m_shift_reg[6:0], m_sample_reg};
                m_bit_reg <= m_bit_reg + 1'b1;
              end else begin
                m_bit_reg <= '0;
                m_addr_phase_reg <= 1'b0;
                // A refused address or byte, or the last byte, ends the transfer.
                if ((!m_read_reg || m_addr_phase_reg) && m_sample_reg) begin
                  o_m_nack <= 1'b1;
                end
                if (((!m_read_reg || m_addr_phase_reg) && m_sample_reg) ||
                    (!m_addr_phase_reg && m_left_reg == two_wire_pkg::ONE_BYTE)) begin
                  o_m_done <= m_keep_reg;
                  m_state_reg <= m_keep_reg ? two_wire_pkg::M_HELD : two_wire_pkg::M_STOP_A;
                end else if (!m_addr_phase_reg) begin
                  m_left_reg <= m_left_reg - 1'b1;
                end
              end
            end
          end
        end
        two_wire_pkg::M_STOP_A: begin
          if (m_cnt_reg == DATA_AT) begin
            m_sda_reg <= 1'b1;
          end
          if (m_cnt_reg == HALF_LAST) begin
            m_cnt_reg <= '0;
            m_state_reg <= two_wire_pkg::M_STOP_B;
          end else begin
            m_cnt_reg <= m_cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Slave engine.
  // ----------------------------------------------------------------
  // Bits are taken on SCL rise; SDA is changed only after SCL has fallen.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b || i_serial_bus_power_reduce) begin
      s_state_reg <= two_wire_pkg::S_IDLE;
      s_bit_reg <= '0;
      s_shift_reg <= 8'h00;
      s_ack_reg <= 1'b0;
      s_mack_reg <= 1'b0;
      s_gc_reg <= 1'b0;
      s_sda_reg <= 1'b0;
      s_hold_reg <= 1'b0;
    end else if (start_det || stop_det) begin
      s_state_reg <= start_det ? two_wire_pkg::S_ADDR : two_wire_pkg::S_IDLE;
      s_bit_reg <= '0;
      s_sda_reg <= 1'b0;
      s_hold_reg <= 1'b0;
      s_gc_reg <= 1'b0;
    end else if (s_hold_reg) begin
      // SCL stays low until room or a byte is there, so no bit is lost.
      if (s_push) begin
        s_ack_reg <= i_s_accept;
        s_sda_reg <= i_s_accept;
        s_hold_reg <= 1'b0;
      end else if (s_load) begin
        s_shift_reg <= i_tx_data;
        s_sda_reg <= ~i_tx_data[7];
        s_bit_reg <= '0;
        s_hold_reg <= 1'b0;
      end
    end else begin
      if (scl_line.rise && s_bit_reg != two_wire_pkg::BITS_PACKET &&
          (s_state_reg != two_wire_pkg::S_IDLE) && (s_state_reg != two_wire_pkg::S_SKIP)) begin
        s_bit_reg <= s_bit_reg + 1'b1;
        if (s_bit_reg != two_wire_pkg::BIT_ACK_SLOT) begin
          s_shift_reg <= {s_shift_reg[6:0], sda_line.level};
        end else begin
          s_mack_reg <= ~sda_line.level;
        end
      end
      if (scl_line.fall) begin
        unique case (s_state_reg)
          two_wire_pkg::S_ADDR: begin
            if (s_bit_reg == two_wire_pkg::BIT_ACK_SLOT) begin
              s_ack_reg <= s_match && i_s_accept;
              s_sda_reg <= s_match && i_s_accept;
              s_gc_reg <= (s_addr == two_wire_pkg::GCALL_ADDR);
            end else if (s_bit_reg == two_wire_pkg::BITS_PACKET) begin
              s_sda_reg <= 1'b0;
              s_bit_reg <= '0;
              if (!s_ack_reg) begin
                s_state_reg <= two_wire_pkg::S_SKIP;
              end else if (s_shift_reg[0] == two_wire_pkg::DIR_READ) begin
                s_state_reg <= two_wire_pkg::S_TX;
                s_hold_reg <= 1'b1;
              end else begin
                s_state_reg <= two_wire_pkg::S_RX;
              end
            end
          end
          two_wire_pkg::S_RX: begin
            if (s_bit_reg == two_wire_pkg::BIT_ACK_SLOT) begin
              s_hold_reg <= 1'b1;
            end else if (s_bit_reg == two_wire_pkg::BITS_PACKET) begin
              s_sda_reg <= 1'b0;
              s_bit_reg <= '0;
              if (!s_ack_reg) begin
                s_state_reg <= two_wire_pkg::S_SKIP;
              end
            end
          end
          two_wire_pkg::S_TX: begin
            if (s_bit_reg == two_wire_pkg::BIT_ACK_SLOT) begin
              s_sda_reg <= 1'b0;
            end else if (s_bit_reg == two_wire_pkg::BITS_PACKET) begin
              // A refused byte ends our sending; SDA stays released.
              s_hold_reg <= s_mack_reg;
              s_state_reg <= s_mack_reg ? two_wire_pkg::S_TX : two_wire_pkg::S_SKIP;
            end else if (s_bit_reg != '0) begin
              s_sda_reg <= ~s_shift_reg[7];
            end
          end
          two_wire_pkg::S_IDLE, two_wire_pkg::S_SKIP: begin
            s_sda_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Two-entry receive buffer.
  // ----------------------------------------------------------------
  // The head is the output register; the second entry absorbs a stalled reader.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b || i_serial_bus_power_reduce) begin
      o_rx_data <= 8'h00;
      o_rx_valid <= 1'b0;
      buf1_reg <= 8'h00;
      buf1_valid_reg <= 1'b0;
    end else if (pop) begin
      o_rx_valid <= buf1_valid_reg | push;
      o_rx_data <= buf1_valid_reg ? buf1_reg : push_data;
      buf1_valid_reg <= buf1_valid_reg & push;
      buf1_reg <= push_data;
    end else if (push && !o_rx_valid) begin
      o_rx_valid <= 1'b1;
      o_rx_data <= push_data;
    end else if (push) begin
      buf1_valid_reg <= 1'b1;
      buf1_reg <= push_data;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs and pins.
  // ----------------------------------------------------------------
  // Pins are only ever pulled low; a released line is left to the pull-up.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b || i_serial_bus_power_reduce) begin
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_tx_taken <= 1'b0;
      o_bus_busy <= 1'b0;
      o_start_seen <= 1'b0;
      o_stop_seen <= 1'b0;
      o_s_addressed <= 1'b0;
      o_s_gcall <= 1'b0;
    end else begin
      o_scl_oe <= m_scl_drive | s_hold_reg;
      o_sda_oe <= m_sda_reg | s_sda_reg;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
      o_tx_taken <= m_load | s_load;
      o_bus_busy <= bus_busy_reg;
      o_start_seen <= start_det;
      o_stop_seen <= stop_det;
      o_s_addressed <= (s_state_reg == two_wire_pkg::S_RX) || (s_state_reg == two_wire_pkg::S_TX);
      o_s_gcall <= s_gc_reg && (s_state_reg == two_wire_pkg::S_RX);
    end
  end

endmodule // two_wire_bus_framing

// File: two_wire_pkg.sv
// Shared constants and state types for the two-wire bus framing block.
package two_wire_pkg;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_HALF_NS = 5000;
  // A least time, so the cycle count rounds up.
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // Packet layout and addresses.
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BITS_PACKET = 4'h9;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [3:0] RESERVED_HI = 4'hF;
  localparam logic DIR_READ = 1'b1;
  localparam logic [7:0] ONE_BYTE = 8'h01;

  // ----------------------------------------------------------------
  // State types.
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    M_IDLE, M_HELD, M_START_A, M_START_B, M_LOW, M_HIGH, M_STOP_A, M_STOP_B, M_STOP_C
  } m_state_t;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_TX, S_SKIP} s_state_t;

endpackage

// File: two_wire_line_if.sv
// Synchronised level and edge strobes of one bus line.
`timescale 1ns/1ps
interface two_wire_line_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// File: two_wire_line_sync.sv
// Two-flop synchroniser and edge finder for one bus line.
`timescale 1ns/1ps
module two_wire_line_sync (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Raw pin level.
  input wire logic i_pin,
  // Synchronised line.
  two_wire_line_if.src o_line
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // The lines idle high through the pull-ups, so reset to high avoids a false edge.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Only the second flop and its delayed copy feed logic.
  assign o_line.level = sync_reg;
  assign o_line.rise = sync_reg & ~prev_reg;
  assign o_line.fall = ~sync_reg & prev_reg;

endmodule // two_wire_line_sync

// File: two_wire_bus_framing_props.sv
// Port checker for the two-wire bus framing block.
`timescale 1ns/1ps
module two_wire_bus_framing_props (
  // Clock, reset and inputs.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_serial_bus_power_reduce,
  input wire logic i_m_valid,
  input wire logic i_rx_ready,
  // Watched outputs.
  input wire logic o_m_taken,
  input wire logic o_m_done,
  input wire logic o_m_nack,
  input wire logic o_rx_valid,
  input wire logic [7:0] o_rx_data,
  input wire logic o_bus_busy,
  input wire logic o_start_seen,
  input wire logic o_stop_seen,
  input wire logic o_scl_out,
  input wire logic o_scl_oe,
  input wire logic o_sda_out,
  input wire logic o_sda_oe
);
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // Bounds are loose on purpose: they cover a slave stretching SCL.
  sequence s_start_soon; ##[1:40] o_start_seen; endsequence
  sequence s_stop_soon; ##[1:120] o_stop_seen; endsequence
  AST_PINS_OPEN_DRAIN: assert property (o_scl_out == 1'b0 && o_sda_out == 1'b0)
    else $error("Pin driven high.");
  AST_POWER_OFF: assert property (i_serial_bus_power_reduce |=> !o_scl_oe && !o_sda_oe && !o_bus_busy)
    else $error("Block active while powered down.");
  AST_BUSY_FROM_START: assert property ($rose(o_bus_busy) |-> o_start_seen || $past(o_start_seen))
    else $error("Busy without start.");
  AST_FREE_AFTER_STOP: assert property ($fell(o_bus_busy) |->
    o_stop_seen || $past(o_stop_seen) || $past(i_serial_bus_power_reduce))
    else $error("Bus freed without stop.");
  AST_TAKEN_NEEDS_REQ: assert property (o_m_taken |-> $past(i_m_valid))
    else $error("Request taken without valid.");
  AST_START_AFTER_TAKEN: assert property (o_m_taken |-> s_start_soon)
    else $error("No start after request.");
  AST_NACK_THEN_STOP: assert property (o_m_nack |-> s_stop_soon)
    else $error("No stop after refusal.");
  AST_RX_HELD: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
    else $error("Receive word lost in stall.");
  AST_DONE_RELEASED: assert property (o_m_done && !o_bus_busy |-> !o_sda_oe && !o_scl_oe)
    else $error("Lines held after stop.");
endmodule // two_wire_bus_framing_props
bind two_wire_bus_framing two_wire_bus_framing_props two_wire_bus_framing_props_inst (.*);

// File: two_wire_peer.sv
// Behavioural slave on the shared bus, with optional SCL stretch.
`timescale 1ns/1ps
module two_wire_peer #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter int STRETCH_NS = 0
) (
  // Bus lines as seen on the wire.
  input wire logic scl,
  input wire logic sda,
  // Pull-down enables and received byte.
  output logic scl_oe,
  output logic sda_oe,
  output logic got,
  output logic [7:0] byte_q
);
  logic [8:0] sh = 9'h000;
  int cnt = 0;
  logic sel = 1'b0;
  logic first = 1'b0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    got = 1'b0;
    byte_q = 8'h00;
  end
  // Start and stop are SDA edges while SCL is high.
  always @(negedge sda) if (scl) begin cnt = 0; first = 1'b1; sel = 1'b0; end
  always @(posedge sda) if (scl) begin sel = 1'b0; first = 1'b0; end
  // Bits are taken MSB first on each rising SCL.
  always @(posedge scl) begin sh = {sh[7:0], sda}; cnt = cnt + 1; end
  // Acknowledge slot opens at the fall after bit eight; SDA released otherwise.
  always @(negedge scl) begin
    sda_oe = 1'b0;
    got = 1'b0;
    if (cnt == 8) begin
      if (first) sel = (sh[7:1] == ADDR) && !sh[0];
      else if (sel) begin byte_q = sh[7:0]; got = 1'b1; end
      sda_oe = sel;
      // A slow slave holds SCL low so the master must wait.
      if (sel && STRETCH_NS > 0) begin scl_oe = 1'b1; #(STRETCH_NS) scl_oe = 1'b0; end
    end
    if (cnt == 9) begin cnt = 0; first = 1'b0; end
  end
endmodule // two_wire_peer

// File: testbench.sv
// Self-checking bench: writes to a peer, a reserved address, itself and a general call.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst_b = 1'b0, pwr = 1'b1, m_valid = 1'b0, tx_valid = 1'b0;
  logic rx_ready = 1'b0, gcall = 1'b0, rd = 1'b0, keep = 1'b0, acc = 1'b1;
  logic s_addr, s_gcall, addr_q = 1'b0;
  logic [6:0] m_addr = 7'h00;
  logic [7:0] tx_data = 8'h00;
  logic m_taken, m_done, m_nack, tx_taken, rx_valid, scl_oe, sda_oe, p_scl_oe, p_sda_oe, p_got;
  logic [7:0] rx_data, p_byte;
  logic [9:0] exp_q[$];
  int n_fail = 0, n_compared = 0;
  // Wired-AND with pull-ups: any enable pulls the line low.
  wire logic scl = !(scl_oe | p_scl_oe);
  wire logic sda = !(sda_oe | p_sda_oe);
  always #12.5 clk = ~clk;
  two_wire_bus_framing #(.HALF_CYC(8)) two_wire_bus_framing_inst (.i_ref_clk(clk),
    .i_rst_b(rst_b), .i_serial_bus_power_reduce(pwr), .i_own_addr(7'h35),
    .i_gcall_enable(gcall), .i_s_accept(acc), .i_m_valid(m_valid), .i_m_addr(m_addr),
    .i_m_read(rd), .i_m_count(8'h01), .i_m_keep_bus(keep), .o_m_taken(m_taken),
    .o_m_done(m_done), .o_m_nack(m_nack), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_taken(tx_taken), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready),
    .o_bus_busy(), .o_start_seen(), .o_stop_seen(), .o_s_addressed(s_addr), .o_s_gcall(s_gcall),
    .i_scl_in(scl), .o_scl_out(), .o_scl_oe(scl_oe), .i_sda_in(sda), .o_sda_out(),
    .o_sda_oe(sda_oe));
  two_wire_peer #(.ADDR(7'h2A), .STRETCH_NS(700)) two_wire_peer_inst (.scl(scl), .sda(sda),
    .scl_oe(p_scl_oe), .sda_oe(p_sda_oe), .got(p_got), .byte_q(p_byte));
  // Takes the oldest note and compares it with a result {kind, byte}.
  task check(input logic [9:0] got);
    logic [9:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3FF;
    n_compared++;
    if (got !== e) begin
      n_fail++;
      $display("MISMATCH %0t: result %h, expected %h", $time, got, e);
    end
  endtask
  // Results: refusal, word out of the receive buffer, byte taken by the peer.
  always @(posedge clk) begin
    if (m_nack === 1'b1) check({2'b01, 8'h00});
    if (rx_valid === 1'b1 && rx_ready === 1'b1) check({2'b10, rx_data});
    // The own slave becoming addressed is a result {0, general call flag}.
    if (s_addr === 1'b1 && addr_q !== 1'b1) check({9'h000, s_gcall});
    addr_q = s_addr;
  end
  always @(posedge p_got) check({2'b11, p_byte});
  // Random receiver stalls exercise the two-entry buffer.
  always @(negedge clk) rx_ready = 1'($urandom);
  // One master transfer of one byte, a write or a read as rd sets it; the expected result is noted first.
  task xfer(input logic [6:0] a, input logic [9:0] e);
    int t;
    exp_q.push_back(e);
    @(negedge clk);
    m_addr = a;
    tx_data = e[7:0];
    m_valid = 1'b1;
    tx_valid = 1'b1;
    for (t = 0; t < 500 && m_taken !== 1'b1; t++) @(negedge clk);
    m_valid = 1'b0;
    for (t = 0; t < 9000 && m_done !== 1'b1; t++) begin
      @(negedge clk);
      if (tx_taken === 1'b1) tx_valid = 1'b0;
    end
    tx_valid = 1'b0;
    if (t >= 9000) begin
      n_fail++;
      $display("MISMATCH %0t: transfer did not finish", $time);
    end
    $display("Test to address %h ended.", a);
  endtask
  task results;
    if (exp_q.size() > 0) n_fail++;
    $display("Compared %0d, failed %0d.", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence; power reduce is released only after reset has settled.
  initial begin
    void'($urandom(60));
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    pwr = 1'b0;
    gcall = 1'b1;
    repeat (4) @(negedge clk);
    xfer(7'h2A, {2'b11, 8'($urandom)});
    xfer(7'h78, 10'h100);
    exp_q.push_back(10'h000);
    xfer(7'h35, {2'b10, 8'($urandom)});
    // A busy own slave refuses its address, so the master must stop.
    acc = 1'b0;
    xfer(7'h35, 10'h100);
    acc = 1'b1;
    // Read one byte back from the own slave and park the bus afterwards.
    rd = 1'b1;
    keep = 1'b1;
    exp_q.push_back(10'h000);
    xfer(7'h35, {2'b10, 8'($urandom)});
    rd = 1'b0;
    keep = 1'b0;
    // The general call follows as a repeated START, always as a write.
    exp_q.push_back(10'h001);
    xfer(7'h00, {2'b10, 8'($urandom)});
    repeat (200) @(negedge clk);
    results();
  end
  // A hang is cut short well beyond the expected run.
  initial begin
    #1000000;
    n_fail++;
    $display("MISMATCH %0t: timeout", $time);
    results();
  end
endmodule // testbench
